//--- core/vpc_controller.sv
// host sequencer that drives the synthesis section through its port registers
module vpc_controller
	import vpc_pkg::*;
#(
	parameter int cycles_per_tick = cycles_per_ms
)(
	input  wire logic       clock,
	input  wire logic       reset,
	// user side
	input  wire logic       cmd_init,
	input  wire logic       crystal_mode,
	input  wire logic       external_memory,
	input  wire logic       cmd_play,
	input  wire logic [7:0] play_phrase,
	input  wire logic       cmd_stop,
	input  wire logic       cmd_finish,
	output logic            ready,
	output logic            cmd_error,
	output logic            phrase_started,
	output logic            sound_busy,
	// device side
	output logic            sfr_write,
	output logic            sfr_read,
	output logic [7:0]      sfr_addr,
	output logic [3:0]      sfr_wdata,
	input  wire logic [3:0] sfr_rdata,
	input  wire logic       synth_irq,
	input  wire logic       busy_low_out
);

	vpc_state_t  state;
	vpc_state_t  next_state;
	logic [7:0]  phrase;
	logic        sending_stop;
	logic        use_crystal;
	logic        use_external;
	logic        timer_start;
	logic        timer_done;
	logic [1:0]  irq_sync;
	logic        irq_seen;
	logic [1:0]  busy_sync;
	logic        wr_now;
	logic [7:0]  wr_addr;
	logic [3:0]  wr_data;

	function automatic logic phrase_ok(input logic [7:0] code);
		phrase_ok = (code != stop_code) && (code <= last_user_phrase);
	endfunction

	function automatic logic [3:0] one_bit(input int pos);
		one_bit = 4'(4'h1 << pos);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irq_sync  <= 2'h0;
			busy_sync <= 2'h3;
			irq_seen  <= 1'b0;
		end
		else
		begin
			irq_sync  <= {irq_sync[0], synth_irq};
			busy_sync <= {busy_sync[0], busy_low_out};
			irq_seen  <= irq_sync[1];
		end
	end

	assign sound_busy = !busy_sync[1];

	vpc_ms_timer #(
		.cycles_per_tick (cycles_per_tick)
	) settle_timer (
		.clock   (clock),
		.reset   (reset),
		.start   (timer_start),
		.wait_ms (use_crystal ? crystal_settle_ms : rc_settle_ms),
		.done    (timer_done)
	);

	assign timer_start = (state == vpc_osc);

	////////////////////////////////////////////////////////////////////////
	// sequence
	always_comb
	begin
		next_state = state;
		case (state)
			vpc_idle:     if (cmd_init) next_state = vpc_route_dir;
			vpc_route_dir: next_state = vpc_route;
			vpc_route:    next_state = vpc_mem_dir;
			vpc_mem_dir:  next_state = vpc_mem;
			vpc_mem:      next_state = vpc_ctl_dir;
			vpc_ctl_dir:  next_state = vpc_cs_off;
			vpc_cs_off:   next_state = vpc_osc;
			vpc_osc:      next_state = vpc_osc_wait;
			vpc_osc_wait: if (timer_done) next_state = vpc_rate;
			vpc_rate:     next_state = vpc_pcie;
			vpc_pcie:     next_state = vpc_ie_on;
			vpc_ie_on:    next_state = vpc_master_irq_enable;
			vpc_master_irq_enable:     next_state = vpc_release;
			vpc_release:  next_state = vpc_ready;
			vpc_ready:
			begin
				if (cmd_finish)
					next_state = vpc_fin_reset;
				else if (cmd_stop)
					next_state = vpc_addr_hi;
				else if (cmd_play && phrase_ok(play_phrase))
					next_state = vpc_rearm;
			end
			vpc_rearm:    next_state = vpc_poll;
			vpc_poll:     next_state = vpc_poll_gap;
			vpc_poll_gap: next_state = vpc_poll_chk;
			// wait for the next-phrase monitor before a play transfer; a stop goes straight to vpc_addr_hi
			vpc_poll_chk: next_state = sfr_rdata[next_phrase_monitor] ? vpc_addr_hi : vpc_poll;
			vpc_addr_hi:  next_state = vpc_addr_lo;
			vpc_addr_lo:  next_state = vpc_cs_on;
			vpc_cs_on:    next_state = vpc_start_hi;
			vpc_start_hi: next_state = vpc_start_lo;
			vpc_start_lo: next_state = sending_stop ? vpc_cs_done : vpc_wait_irq;
			vpc_wait_irq:
			begin
				if (irq_sync[1] && !irq_seen)
					next_state = vpc_irq_off;
				else if (cmd_stop)
					next_state = vpc_addr_hi;
			end
			vpc_irq_off:  next_state = vpc_cs_done;
			vpc_cs_done:  next_state = vpc_ready;
			vpc_fin_reset: next_state = vpc_fin_osc;
			vpc_fin_osc:  next_state = vpc_idle;
			default:      next_state = vpc_idle;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state <= vpc_idle;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// captured options and phrase
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			use_crystal  <= 1'b0;
			use_external <= 1'b0;
		end
		else if (state == vpc_idle && cmd_init)
		begin
			use_crystal  <= crystal_mode;
			use_external <= external_memory;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			phrase       <= stop_code;
			sending_stop <= 1'b0;
		end
		else if (((state == vpc_ready && !cmd_finish) || state == vpc_wait_irq) && cmd_stop)
		begin
			phrase       <= stop_code;
			sending_stop <= 1'b1;
		end
		else if (state == vpc_ready && cmd_play && !cmd_finish)
		begin
			phrase       <= play_phrase;
			sending_stop <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register write chosen by state
	always_comb
	begin
		wr_now  = 1'b1;
		wr_addr = 8'h00;
		wr_data = 4'h0;
		case (state)
			vpc_route_dir:
			begin
				wr_addr = output_route_direction_addr;
				wr_data = route_dir_value;
			end
			vpc_route:
			begin
				wr_addr = output_route_reg_addr;
				wr_data = route_voice_value;
			end
			vpc_mem_dir:
			begin
				wr_addr = memory_select_direction_addr;
				wr_data = memory_dir_value;
			end
			vpc_mem:       // synthesis select stays 0, source bit picks the memory
			begin
				wr_addr = memory_select_port_addr;
				wr_data = use_external ? one_bit(memory_source_bit) : 4'h0;
			end
			vpc_ctl_dir:
			begin
				wr_addr = synth_control_direction_addr;
				wr_data = control_dir_value;
			end
			vpc_cs_off:
			begin
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_select_bit);
			end
			vpc_osc:
			begin
				wr_addr = fast_osc_control_addr;
				wr_data = one_bit(osc_enable_bit) | (use_crystal ? one_bit(osc_crystal_bit) : 4'h0);
			end
			vpc_rate:
			begin
				wr_addr = synth_irq_rate_reg_addr;
				wr_data = one_bit(rate_4khz_bit);
			end
			vpc_pcie:
			begin
				wr_addr = synth_irq_enable_reg_addr;
				wr_data = one_bit(synth_irq_enable_bit);
			end
			vpc_ie_on, vpc_rearm:
			begin
				wr_addr = irq_enable_group_addr;
				wr_data = one_bit(synth_irq_enable_bit);
			end
			vpc_master_irq_enable:
			begin
				wr_addr = master_irq_enable_addr;
				wr_data = one_bit(master_irq_bit);
			end
			vpc_release, vpc_cs_done:
			begin
				// reset released, chip select inactive
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_select_bit) | one_bit(synth_reset_bit);
			end
			vpc_addr_hi:
			begin
				wr_addr = phrase_high_nibble_addr;
				wr_data = phrase[7:4];
			end
			vpc_addr_lo:
			begin
				wr_addr = phrase_low_nibble_addr;
				wr_data = phrase[3:0];
			end
			vpc_cs_on:
			begin
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_reset_bit);
			end
			vpc_start_hi:
			begin
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_reset_bit) | one_bit(transfer_start_bit);
			end
			// the falling start bit launches the serial transfer
			vpc_start_lo:
			begin
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_reset_bit);
			end
			vpc_irq_off:
			begin
				wr_addr = irq_enable_group_addr;
				wr_data = 4'h0;
			end
			vpc_fin_reset:
			begin
				wr_addr = synth_control_reg_addr;
				wr_data = one_bit(synth_select_bit);
			end
			vpc_fin_osc:
			begin
				wr_addr = fast_osc_control_addr;
				wr_data = 4'h0;
			end
			default:       wr_now = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// device port outputs, registered
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sfr_write <= 1'b0;
			sfr_read  <= 1'b0;
			sfr_addr  <= 8'h00;
			sfr_wdata <= 4'h0;
		end
		else
		begin
			sfr_write <= wr_now;
			sfr_read  <= (state == vpc_poll);
			sfr_addr  <= (state == vpc_poll) ? monitor_reg_addr : wr_addr;
			sfr_wdata <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// user status
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			cmd_error      <= 1'b0;
			phrase_started <= 1'b0;
		end
		else
		begin
			// a bad code is refused and never reaches the device
			cmd_error      <= (state == vpc_ready) && cmd_play && !cmd_stop && !cmd_finish
			                  && !phrase_ok(play_phrase);
			phrase_started <= (state == vpc_irq_off);
		end
	end

	assign ready = (state == vpc_ready);

endmodule

//--- core/vpc_ms_timer.sv
// millisecond wait timer built on a one-cycle tick divider
module vpc_ms_timer
	import vpc_pkg::*;
#(
	parameter int cycles_per_tick = cycles_per_ms
)(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [3:0] wait_ms,
	output logic            done
);

	logic [31:0] divider;
	logic        tick;
	logic [3:0]  remaining;

	////////////////////////////////////////////////////////////////////////
	// divider restarts with each wait so the first millisecond is whole
	always_ff @(posedge clock)
	begin
		if (reset || start || divider == 32'(cycles_per_tick - 1))
			divider <= 32'h0;
		else
			divider <= divider + 32'h1;
	end

	assign tick = (divider == 32'(cycles_per_tick - 1)) && !start;

	always_ff @(posedge clock)
	begin
		if (reset)
			remaining <= 4'h0;
		else if (start)
			remaining <= wait_ms;
		else if (tick && remaining != 4'h0)
			remaining <= remaining - 4'h1;
	end

	assign done = (remaining == 4'h0) && !start;

endmodule

//--- core/vpc_pkg.sv
// constants, states and register map for the voice phrase controller
// What this block does
// - phrase codes 0x01 to 0xf7 select user phrases, at most 247
// - code 0xf8 is reserved for test and must never be sent
// - route voice: both route direction bits to 1, both route bits to 0
// - memory direction bits to 1, synthesis selected, source bit picks ROM or external
// - control direction bits to 1 and chip select made inactive first
// - enable fast oscillator, wait 10 ms for crystal or 5 ms for RC
// - enable synthesis interrupt: rate, enable register, group enable, master
// - release synthesis reset, load phrase into high and low nibble ports
// - with chip select active, start bit written 1 then 0 begins transfer
// - on interrupt clear group enable, deselect; re-enable for each phrase
// - finish: put synthesis in reset, then stop the fast oscillator
package vpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// device register offsets
	localparam logic [7:0] monitor_reg_addr            = 8'h01;
	localparam logic [7:0] phrase_low_nibble_addr      = 8'h02;
	localparam logic [7:0] phrase_high_nibble_addr     = 8'h03;
	localparam logic [7:0] irq_enable_group_addr       = 8'h10;
	localparam logic [7:0] master_irq_enable_addr      = 8'h11;
	localparam logic [7:0] memory_select_port_addr     = 8'h24;
	localparam logic [7:0] memory_select_direction_addr = 8'h25;
	localparam logic [7:0] synth_control_reg_addr      = 8'h5a;
	localparam logic [7:0] synth_control_direction_addr = 8'h5b;
	localparam logic [7:0] output_route_reg_addr       = 8'h5c;
	localparam logic [7:0] output_route_direction_addr  = 8'h5d;
	localparam logic [7:0] synth_irq_rate_reg_addr     = 8'h5e;
	localparam logic [7:0] synth_irq_enable_reg_addr   = 8'h5f;
	localparam logic [7:0] fast_osc_control_addr       = 8'h62;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int transfer_start_bit   = 0;
	localparam int synth_reset_bit      = 1;
	localparam int synth_select_bit     = 2;
	localparam int next_phrase_monitor  = 1;
	localparam int synth_or_transfer_bit = 2;
	localparam int memory_source_bit    = 3;
	localparam int osc_enable_bit       = 1;
	localparam int osc_crystal_bit      = 2;
	localparam int synth_irq_enable_bit = 3;
	localparam int rate_4khz_bit        = 0;
	localparam int master_irq_bit       = 0;

	////////////////////////////////////////////////////////////////////////
	// values written
	localparam logic [3:0] route_dir_value   = 4'h3;
	localparam logic [3:0] route_voice_value = 4'h0;
	localparam logic [3:0] memory_dir_value  = 4'hc;
	localparam logic [3:0] control_dir_value = 4'h7;
	localparam logic [7:0] stop_code         = 8'h00;
	localparam logic [7:0] last_user_phrase  = 8'hf7;
	localparam logic [7:0] test_code         = 8'hf8;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int clock_khz          = 10000;
	localparam int cycles_per_ms      = clock_khz;
	localparam logic [3:0] crystal_settle_ms = 4'd10;
	localparam logic [3:0] rc_settle_ms      = 4'd5;

	typedef enum logic [4:0] {
		vpc_idle, vpc_route_dir, vpc_route, vpc_mem_dir, vpc_mem, vpc_ctl_dir,
		vpc_cs_off, vpc_osc, vpc_osc_wait, vpc_rate, vpc_pcie, vpc_ie_on, vpc_master_irq_enable,
		vpc_release, vpc_ready, vpc_rearm, vpc_poll, vpc_poll_gap, vpc_poll_chk,
		vpc_addr_hi, vpc_addr_lo, vpc_cs_on, vpc_start_hi, vpc_start_lo,
		vpc_wait_irq, vpc_irq_off, vpc_cs_done, vpc_fin_reset, vpc_fin_osc
	} vpc_state_t;

endpackage

//--- verif/tb_voice_phrase_control.sv
// self-checking bench for the voice phrase controller
module tb_voice_phrase_control
	import vpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int tick = 4;
	logic       clock, reset, cmd_init, crystal_mode, external_memory, cmd_play, cmd_stop, cmd_finish, slow;
	logic [7:0] play_phrase, sfr_addr;
	logic [3:0] sfr_wdata, sfr_rdata;
	logic       ready, cmd_error, phrase_started, sound_busy, sfr_write, sfr_read, synth_irq, busy_low_out;
	int         n_errors, comparisons, cycles;
	vpc_controller #(.cycles_per_tick(tick)) u_dut (.clock(clock), .reset(reset), .cmd_init(cmd_init),
		.crystal_mode(crystal_mode), .external_memory(external_memory), .cmd_play(cmd_play),
		.play_phrase(play_phrase), .cmd_stop(cmd_stop), .cmd_finish(cmd_finish), .ready(ready),
		.cmd_error(cmd_error), .phrase_started(phrase_started), .sound_busy(sound_busy), .sfr_write(sfr_write),
		.sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.synth_irq(synth_irq), .busy_low_out(busy_low_out));
	vpc_device_model u_dev (.clock(clock), .reset(reset), .slow(slow), .sfr_write(sfr_write), .sfr_read(sfr_read),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .synth_irq(synth_irq),
		.busy_low_out(busy_low_out));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic sig);
		@(negedge clock);
		sig = 1'b1;
		@(negedge clock);
		sig = 1'b0;
	endtask
	// sel 0 waits for ready, sel 1 for the started pulse
	task automatic wait_for(input int sel, input int limit);
		int i;
		i = 0;
		while ((sel ? phrase_started : ready) !== 1'b1 && i < limit)
		begin
			@(negedge clock);
			i++;
		end
		check(sel ? phrase_started : ready, 1'b1);
	endtask
	task automatic t_init(input logic cry, input logic ext);
		crystal_mode = cry;
		external_memory = ext;
		pulse(cmd_init);
		wait_for(0, 3000);
		// the last write is on the bus as ready rises and lands one edge later
		@(negedge clock);
		check(u_dev.regs[8'h5d], 4'h3);
		check(u_dev.regs[8'h5c], 4'h0);
		check(u_dev.regs[8'h25], 4'hc);
		check(u_dev.regs[8'h24], {ext, 3'h0});
		check(u_dev.regs[8'h5b], 4'h7);
		check(u_dev.regs[8'h62], cry ? 4'h6 : 4'h2);
		check(u_dev.t_rate - u_dev.t_osc >= (cry ? 10 : 5) * tick, 1'b1);
		check({u_dev.regs[8'h5e][0], u_dev.regs[8'h5f][3], u_dev.regs[8'h10][3], u_dev.regs[8'h11][0]}, 4'hf);
		check(u_dev.regs[8'h5a], 4'h6);
		$display("init test done");
	endtask
	task automatic t_play(input logic [7:0] code);
		int n;
		n = u_dev.n_xfer;
		play_phrase = code;
		pulse(cmd_play);
		wait_for(1, 3000);
		check(u_dev.last_code, code);
		check(u_dev.n_xfer, n + 1);
		wait_for(0, 20);
		check(sound_busy, 1'b1);
		$display("play test done");
	endtask
	task automatic t_refuse(input logic [7:0] code);
		int n;
		n = u_dev.n_xfer;
		play_phrase = code;
		pulse(cmd_play);
		check(cmd_error, 1'b1);
		repeat (10) @(negedge clock);
		check(u_dev.n_xfer, n);
		check(ready, 1'b1);
		$display("refuse test done");
	endtask
	task automatic t_slow();
		int n;
		n = u_dev.n_xfer;
		slow = 1'b1;
		play_phrase = 8'h42;
		pulse(cmd_play);
		repeat (40) @(negedge clock);
		check(u_dev.n_xfer, n);
		slow = 1'b0;
		wait_for(1, 3000);
		check(u_dev.n_xfer, n + 1);
		wait_for(0, 20);
		$display("slow test done");
	endtask
	task automatic t_stop();
		int n;
		n = u_dev.n_stop;
		t_play(8'h30);
		pulse(cmd_stop);
		wait_for(0, 50);
		repeat (16) @(negedge clock);
		check(sound_busy, 1'b0);
		check(u_dev.n_stop, n + 1);
		// stop sent while a second phrase still waits for its interrupt
		t_play(8'h30);
		play_phrase = 8'h31;
		pulse(cmd_play);
		repeat (25) @(negedge clock);
		check(ready, 1'b0);
		pulse(cmd_stop);
		wait_for(0, 50);
		repeat (16) @(negedge clock);
		check(sound_busy, 1'b0);
		check(u_dev.n_stop, n + 2);
		check(u_dev.last_code, 8'h30);
		$display("stop test done");
	endtask
	task automatic t_finish();
		pulse(cmd_finish);
		repeat (8) @(negedge clock);
		check(u_dev.regs[8'h5a], 4'h4);
		check(u_dev.regs[8'h62], 4'h0);
		check(ready, 1'b0);
		check(sound_busy, 1'b0);
		$display("finish test done");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			$display("MISMATCH at %0t: timeout", $time);
			results();
		end
	end
	initial
	begin
		{reset, cmd_init, crystal_mode, external_memory, cmd_play, cmd_stop, cmd_finish, slow} = 8'h80;
		play_phrase = 8'h00;
		{n_errors, comparisons, cycles} = '0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		t_init(1'b1, 1'b0);
		t_play(8'h01);
		t_play(8'hf7);
		t_refuse(8'h00);
		t_refuse(8'hf8);
		t_refuse(8'hff);
		t_slow();
		t_play(8'h11);
		t_play(8'h22);
		t_stop();
		t_finish();
		t_init(1'b0, 1'b1);
		t_play(8'h80);
		t_finish();
		results();
	end
endmodule

//--- verif/vpc_controller_props.sv
// concurrent checks on the controller's command and register-bus ports
////////////////////////////////////////////////////////////////////////
module vpc_controller_props
	import vpc_pkg::*;
#(
	parameter int cycles_per_tick = cycles_per_ms
)(
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       cmd_play,
	input wire logic [7:0] play_phrase,
	input wire logic       cmd_stop,
	input wire logic       cmd_finish,
	input wire logic       ready,
	input wire logic       cmd_error,
	input wire logic       phrase_started,
	input wire logic       sfr_write,
	input wire logic       sfr_read,
	input wire logic [7:0] sfr_addr,
	input wire logic [3:0] sfr_wdata
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	let w(a) = sfr_write && sfr_addr == a;
	logic go_play;
	// stop and finish win over play, so only a lone play is judged
	assign go_play = cmd_play && ready && !cmd_stop && !cmd_finish;
	property p_route;
		w(8'h5d) |-> sfr_wdata == 4'h3 ##1 w(8'h5c) && sfr_wdata == 4'h0;
	endproperty
	a_route: assert property (p_route) else $error("route setup order wrong");
	property p_memory;
		w(8'h25) |-> sfr_wdata == 4'hc ##1 w(8'h24) && sfr_wdata[2:0] == 3'h0;
	endproperty
	a_memory: assert property (p_memory) else $error("memory select order wrong");
	property p_osc_wait;
		w(8'h62) && sfr_wdata[1] |=> !sfr_write [*8];
	endproperty
	a_osc_wait: assert property (p_osc_wait) else $error("write during oscillator settle");
	property p_deselect;
		w(8'h5a) && sfr_wdata == 4'h4 |=> w(8'h62);
	endproperty
	a_deselect: assert property (p_deselect) else $error("oscillator write missing");
	property p_osc_stop;
		w(8'h62) && sfr_wdata == 4'h0 |-> $past(w(8'h5a) && sfr_wdata == 4'h4);
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator stopped before reset");
	property p_pair;
		w(8'h03) |=> w(8'h02) ##1 w(8'h5a) && sfr_wdata == 4'h2 ##1 w(8'h5a) && sfr_wdata == 4'h3
			##1 w(8'h5a) && sfr_wdata == 4'h2;
	endproperty
	a_pair: assert property (p_pair) else $error("address load and start order wrong");
	property p_no_test;
		w(8'h03) && sfr_wdata == 4'hf |=> !sfr_wdata[3];
	endproperty
	a_no_test: assert property (p_no_test) else $error("reserved code sent");
	property p_refuse;
		go_play && (play_phrase == 8'h00 || play_phrase > 8'hf7) |=> cmd_error && !w(8'h03);
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad code not refused");
	property p_irq_done;
		phrase_started |-> w(8'h10) && sfr_wdata == 4'h0 ##1 w(8'h5a) && sfr_wdata == 4'h6;
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("interrupt handling order wrong");
	property p_poll;
		sfr_read |-> sfr_addr == 8'h01 && !sfr_write;
	endproperty
	a_poll: assert property (p_poll) else $error("read not aimed at monitor");
	c_started: cover property (phrase_started);
	c_error: cover property (cmd_error);
	c_stop: cover property (w(8'h03) && sfr_wdata == 4'h0);
endmodule
////////////////////////////////////////////////////////////////////////
bind vpc_controller vpc_controller_props #(.cycles_per_tick(cycles_per_tick)) u_props (.clock(clock), .reset(reset),
	.cmd_play(cmd_play), .play_phrase(play_phrase), .cmd_stop(cmd_stop), .cmd_finish(cmd_finish), .ready(ready),
	.cmd_error(cmd_error), .phrase_started(phrase_started), .sfr_write(sfr_write), .sfr_read(sfr_read),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata));

//--- verif/vpc_device_model.sv
// behavioural model of the synthesis section and its port registers
module vpc_device_model
	import vpc_pkg::*;
#(
	parameter int play_len = 60
)(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       slow,
	input  wire logic       sfr_write,
	input  wire logic       sfr_read,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [3:0] sfr_wdata,
	output logic [3:0]      sfr_rdata,
	output logic            synth_irq,
	output logic            busy_low_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]  regs [256];
	logic [7:0]  code_in;
	logic [7:0]  last_code;
	logic [7:0]  pend_code;
	logic        playing;
	logic        pending;
	logic        next_ok;
	logic        next_q;
	logic        toggle;
	logic        start_x;
	logic        half_q;
	logic        samp_en;
	int          xfer;
	int          left;
	int          irq_cnt;
	int          n_xfer;
	int          n_stop;
	int unsigned cyc;
	int unsigned t_osc;
	int unsigned t_rate;
	assign code_in = {regs[8'h03], regs[8'h02]};
	assign busy_low_out = !playing;
	assign synth_irq = irq_cnt != 0;
	assign start_x = sfr_write && sfr_addr == 8'h5a && regs[8'h5a][0] && sfr_wdata[2:0] == 3'h2;
	// one sample per synthesis clock; crystal mode halves that clock, so phrases last twice as long
	assign samp_en = !regs[8'h62][2] || half_q;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock)
	begin
		if (reset || !regs[8'h5a][1])
		begin
			playing <= 1'b0;
			pending <= 1'b0;
			next_ok <= 1'b1;
			xfer <= 0;
			irq_cnt <= 0;
			half_q <= 1'b0;
		end
		else
		begin
			half_q <= !half_q;
			irq_cnt <= (irq_cnt != 0) ? irq_cnt - 1 : 0;
			xfer <= start_x ? 8 : (xfer != 0) ? xfer - 1 : 0;
			if (xfer == 1 && code_in == 8'h00)
			begin
				playing <= 1'b0;
				pending <= 1'b0;
				next_ok <= 1'b1;
			end
			else if (xfer == 1 && playing)
			begin
				pending <= 1'b1;
				pend_code <= code_in;
				next_ok <= 1'b0;
			end
			else if (xfer == 1 || (playing && samp_en && left == 1 && pending))
			begin
				playing <= 1'b1;
				pending <= 1'b0;
				next_ok <= 1'b1;
				left <= play_len;
				last_code <= pending ? pend_code : code_in;
				irq_cnt <= 4;
			end
			else if (playing && samp_en && left == 1)
				playing <= 1'b0;
			else if (playing && samp_en)
				left <= left - 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			foreach (regs[i]) regs[i] <= 4'h0;
			sfr_rdata <= 4'h0;
			{n_xfer, n_stop, cyc, t_osc, t_rate} <= '0;
			toggle <= 1'b0;
			next_q <= 1'b1;
		end
		else
		begin
			cyc <= cyc + 1;
			next_q <= next_ok;
			toggle <= toggle ^ (next_ok & !next_q);
			// an idle bus shows the complement so a stale value never passes
			if (!sfr_read)
				sfr_rdata <= ~sfr_rdata;
			else if (sfr_addr == 8'h01)
				sfr_rdata <= {2'h0, next_ok & !slow, !playing};
			else
				sfr_rdata <= {toggle, regs[sfr_addr][2:0]};
			if (sfr_write)
				regs[sfr_addr] <= sfr_wdata;
			if (start_x)
				n_xfer <= n_xfer + 1;
			if (xfer == 1 && code_in == 8'h00 && regs[8'h5a][1])
				n_stop <= n_stop + 1;
			if (sfr_write && sfr_addr == 8'h62 && sfr_wdata[1])
				t_osc <= cyc;
			if (sfr_write && sfr_addr == 8'h5e)
				t_rate <= cyc;
		end
	end
endmodule
